// ==== sim/seq_model.sv ====
// Machine-side sequence model that drives the sync, calc, offset and cancel request pins.
`timescale 1ns/10ps
module seq_model
(
    input  wire logic       i_clock,
    input  wire logic       i_rst,
    input  wire logic [2:0] i_step,
    output logic            o_sync,
    output logic            o_calc,
    output logic            o_offs,
    output logic            o_cancel
);
    logic chuck_basic_ff;
    logic chuck_sync_ff;
    // ----------------------------------------------------------------
    // Step sequencer
    // ----------------------------------------------------------------
    // Chucks and requests follow the step code one flop apart, so the sync and
    // cancel requests are only raised once their chuck precondition is confirmed.
    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            chuck_basic_ff <= 1'b0;
            chuck_sync_ff  <= 1'b0;
            o_sync         <= 1'b0;
            o_calc         <= 1'b0;
            o_offs         <= 1'b0;
            o_cancel       <= 1'b0;
        end
        else
        begin
            chuck_basic_ff <= i_step >= 3'd2;
            o_sync   <= chuck_basic_ff && i_step >= 3'd2;
            o_calc   <= i_step == 3'd1 || i_step == 3'd2;
            o_offs   <= i_step >= 3'd3;
            chuck_sync_ff <= o_sync && i_step == 3'd4;
            o_cancel <= chuck_basic_ff && chuck_sync_ff;
        end
    end
endmodule // seq_model

// ==== sim/tb.sv ====
// Self-checking bench for the spindle synchronous control block.
`timescale 1ns/10ps
module tb;
    localparam int SC = 8;
    logic        clk, rst, cyc, stb, we, ack, phase_req, rev, hmode, hpulse;
    logic        flag, align, hstep, sync_req, calc_req, offs_req, cancel;
    logic [31:0] wdat, rdat, q;
    logic [7:0]  adr;
    logic [15:0] bspd, sspd, bpos, spos, spd_cmd, pos_tgt, err, off, cdif;
    logic [2:0]  step;
    logic        spdok, phok;
    logic [15:0] tsum;
    int          miscompares, checks, nsteps;
    // ----------------------------------------------------------------
    // Clock, design and sequence model
    // ----------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    spindle_sync_phase_control #(.SCAN_CYCLES(SC)) dut (
        .I_CLOCK(clk), .I_RST(rst), .I_WB_CYC(cyc), .I_WB_STB(stb),
        .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(4'hF), .I_WB_DAT(wdat),
        .O_WB_DAT(rdat), .O_WB_ACK(ack), .I_SPINDLE_SYNC_REQUEST(sync_req),
        .I_PHASE_SYNC_REQUEST(phase_req), .I_ROT_DIR_REVERSE(rev),
        .I_PHASE_SHIFT_CALC_REQUEST(calc_req),
        .I_PHASE_OFFSET_REQUEST(offs_req), .I_ERROR_TEMP_CANCEL(cancel),
        .I_HANDLE_MODE(hmode), .I_HANDLE_PULSE(hpulse),
        .I_BASIC_SPEED(bspd), .I_SYNC_SPEED(sspd), .I_BASIC_POS(bpos),
        .I_SYNC_POS(spos), .O_IN_SPINDLE_SYNC_FLAG(flag),
        .O_SPEED_SYNC_COMPLETE(spdok), .O_PHASE_SYNC_COMPLETE(phok),
        .O_PHASE_ALIGN_EN(align), .O_SYNC_SPEED_CMD(spd_cmd),
        .O_SYNC_POS_TARGET(pos_tgt), .O_SYNC_HANDLE_STEP(hstep));
    seq_model seq (.i_clock(clk), .i_rst(rst), .i_step(step),
        .o_sync(sync_req), .o_calc(calc_req), .o_offs(offs_req),
        .o_cancel(cancel));
    // Counts handle steps passed on to the synchronous spindle.
    always @(posedge clk)
        if (hstep === 1'b1) nsteps++;
    // ----------------------------------------------------------------
    // Tasks and expectation functions
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // One classic cycle; held until ack is sampled, then released.
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r);
        @(posedge clk);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        do @(posedge clk); while (ack !== 1'b1);
        r = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic scans(input int n);
        repeat (n * SC) @(posedge clk);
    endtask
    function automatic logic [15:0] pdiff(logic r, logic [15:0] b, s);
        return r ? b + s : b - s;
    endfunction
    function automatic logic [15:0] tgt(logic r, logic [15:0] b, t, c);
        return r ? t + c - b : b - t - c;
    endfunction
    // Phase within tolerance; the deviation is minus the offset.
    function automatic logic near(logic [15:0] v);
        return v <= 16'h0004 || v >= 16'hfffc;
    endfunction
    task tally_and_finish;
        $display("Checks %0d mismatches %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Cuts a hang short well past the expected run length.
    initial
    begin
        repeat (20000) @(posedge clk);
        miscompares++;
        tally_and_finish();
    end
    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial
    begin
        {rst, cyc, stb, we, adr, wdat, phase_req, rev} = {1'b1, 45'h0};
        {hmode, hpulse, step, bspd, sspd, bpos, spos} = '0;
        {miscompares, checks, nsteps} = '0;
        void'($urandom(32'hdeafdec0));
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        chk({29'h0, flag, align, hstep}, 32'h0000_0000);
        wb(1'b0, spsync_pkg::ADR_PHASE_ERR, 32'h0, q);
        chk(q, spsync_pkg::WORD_ZERO);
        wb(1'b0, 8'h20, 32'h0, q);
        chk(q, 32'h0000_0000);
        scans(2);
        hpulse <= 1'b1;
        @(posedge clk) hpulse <= 1'b0;
        scans(1);
        chk(nsteps, 32'h0000_0001);
        hmode <= 1'b1;
        scans(3);
        hpulse <= 1'b1;
        @(posedge clk) hpulse <= 1'b0;
        scans(1);
        chk(nsteps, 32'h0000_0001);
        hmode <= 1'b0;
        phase_req <= 1'b1;
        scans(3);
        chk({31'h0, align}, 32'h0000_0000);
        phase_req <= 1'b0;
        for (int i = 0; i < 2; i++)
        begin
            rev  <= i[0];
            spos <= 16'($urandom);
            bpos <= 16'($urandom);
            bspd <= 16'($urandom_range(4095));
            off  = i[0] ? 16'($urandom) : 16'h0003;
            @(posedge clk);
            sspd <= i[0] ? -bspd : bspd;
            step <= 3'd1;
            scans(2);
            wb(1'b1, spsync_pkg::ADR_COMMAND, 32'h0000_0001, q);
            step <= 3'd2;
            scans(4);
            phase_req <= 1'b1;
            scans(3);
            err = pdiff(i[0], bpos, spos);
            tsum = err + off;
            chk({31'h0, flag}, 32'h0000_0001);
            chk({31'h0, spdok}, 32'h0000_0001);
            chk({16'h0, spd_cmd}, {16'h0, sspd});
            chk({31'h0, align}, 32'h0000_0000);
            wb(1'b0, spsync_pkg::ADR_PHASE_ERR, 32'h0, q);
            chk(q, {16'h0000, err});
            phase_req <= 1'b0;
            wb(1'b1, spsync_pkg::ADR_OFFSET, {16'h0000, off}, q);
            wb(1'b1, spsync_pkg::ADR_COMMAND, 32'h0000_0002, q);
            step <= 3'd3;
            scans(3);
            phase_req <= 1'b1;
            scans(3);
            chk({31'h0, align}, 32'h0000_0001);
            chk({30'h0, spdok, phok}, {30'h0, 1'b1, near(off)});
            chk(32'(pos_tgt), 32'(tgt(i[0], bpos, tsum, '0)));
            bpos <= bpos + 16'($urandom_range(255));
            step <= 3'd4;
            scans(4);
            cdif = pdiff(i[0], bpos, spos) - tsum;
            chk(32'(pos_tgt), 32'(tgt(i[0], bpos, tsum, cdif)));
            wb(1'b0, spsync_pkg::ADR_CANCEL_DIFF, 32'h0, q);
            chk(q, {16'h0000, cdif});
            step <= 3'd5;
            scans(3);
            chk(32'(pos_tgt), 32'(tgt(i[0], bpos, tsum, '0)));
            step <= 3'd0;
            phase_req <= 1'b0;
            scans(3);
            chk({31'h0, flag}, 32'h0000_0000);
        end
        tally_and_finish();
    end
endmodule // tb

// ==== verilog/scan_divider.sv ====
// Divider that makes the one-cycle scan enable pulse.
`timescale 1ns/10ps
module scan_divider
#(
    parameter int unsigned CYCLES = 125
)
(
    input  wire logic i_clock,
    input  wire logic i_rst,
    output logic      o_tick
);
    localparam int unsigned CW = $clog2(CYCLES + 1);
    logic [CW-1:0] cnt_ff;
    logic [CW-1:0] nxt_cnt;
    logic          tick_ff;
    logic          nxt_tick;

    // Count up and wrap, pulsing once per wrap.
    always_comb
    begin
        nxt_tick = (cnt_ff == CW'(CYCLES - 1));
        nxt_cnt  = nxt_tick ? '0 : cnt_ff + 1'b1;
    end

    // Register the counter and the pulse.
    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            cnt_ff  <= '0;
            tick_ff <= 1'b0;
        end
        else
        begin
            cnt_ff  <= nxt_cnt;
            tick_ff <= nxt_tick;
        end
    end

    assign o_tick = tick_ff;
endmodule // scan_divider

// ==== verilog/spindle_sync_phase_control.sv ====
// Spindle synchronous, phase shift and error cancel control.
`timescale 1ns/10ps
// Overview of operation
// - Direction input 0 gives same rotation, 1 gives reverse rotation.
// - With calc request, save phase error at speed sync of plain command.
// - No phase alignment while a phase shift calculation is requested.
// - Handle pulses never turn the synchronous spindle in handle mode.
// - Offset request aligns to saved error plus commanded offset.
// - Rising cancel input captures the present position difference less the target.
// - While cancel is held, subtract capture, ignoring chuck state.
// - Sync request enters sync mode; sync spindle tracks basic speed.
// - Phase request is ignored outside spindle synchronous mode.
module spindle_sync_phase_control
#(
    parameter int unsigned POS_W       = 16,
    parameter int unsigned SPD_W       = 16,
    parameter int unsigned SPEED_TOL   = 4,
    parameter int unsigned PHASE_TOL   = 4,
    parameter int unsigned SCAN_CYCLES = spsync_pkg::SCAN_CYCLES
)
(
    input  wire logic                    I_CLOCK,
    input  wire logic                    I_RST,
    input  wire logic                    I_WB_CYC,
    input  wire logic                    I_WB_STB,
    input  wire logic                    I_WB_WE,
    input  wire logic [7:0]              I_WB_ADR,
    input  wire logic [3:0]              I_WB_SEL,
    input  wire logic [31:0]             I_WB_DAT,
    output logic      [31:0]             O_WB_DAT,
    output logic                         O_WB_ACK,
    input  wire logic                    I_SPINDLE_SYNC_REQUEST,
    input  wire logic                    I_PHASE_SYNC_REQUEST,
    input  wire logic                    I_ROT_DIR_REVERSE,
    input  wire logic                    I_PHASE_SHIFT_CALC_REQUEST,
    input  wire logic                    I_PHASE_OFFSET_REQUEST,
    input  wire logic                    I_ERROR_TEMP_CANCEL,
    input  wire logic                    I_HANDLE_MODE,
    input  wire logic                    I_HANDLE_PULSE,
    input  wire logic [SPD_W-1:0]        I_BASIC_SPEED,
    input  wire logic [SPD_W-1:0]        I_SYNC_SPEED,
    input  wire logic [POS_W-1:0]        I_BASIC_POS,
    input  wire logic [POS_W-1:0]        I_SYNC_POS,
    output logic                         O_IN_SPINDLE_SYNC_FLAG,
    output logic                         O_SPEED_SYNC_COMPLETE,
    output logic                         O_PHASE_SYNC_COMPLETE,
    output logic                         O_PHASE_ALIGN_EN,
    output logic      [SPD_W-1:0]        O_SYNC_SPEED_CMD,
    output logic      [POS_W-1:0]        O_SYNC_POS_TARGET,
    output logic                         O_SYNC_HANDLE_STEP
);
    localparam int unsigned NP = spsync_pkg::PIN_COUNT;
    localparam int unsigned CW = spsync_pkg::CMD_W;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Phase of the basic spindle seen from the synchronous spindle.
    function automatic logic [POS_W-1:0] pdiff(input logic [POS_W-1:0] b,
        input logic [POS_W-1:0] s, input logic rev);
        return rev ? POS_W'(b + s) : POS_W'(b - s);
    endfunction

    // True when a wrapped signed deviation is inside the tolerance.
    function automatic logic near_zero(input logic [POS_W-1:0] v);
        logic [POS_W-1:0] m;
        m = v[POS_W-1] ? POS_W'(~v + 1'b1) : v;
        return m <= POS_W'(PHASE_TOL);
    endfunction

    // Merge write data into a word under the byte enables.
    function automatic logic [31:0] wmerge(input logic [31:0] old,
        input logic [31:0] dat, input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
        begin
            if (sel[i])
                r[8*i +: 8] = dat[8*i +: 8];
        end
        return r;
    endfunction

    // ------------------------------------------------------------------
    // Pin synchronisers and scan sampling
    // ------------------------------------------------------------------
    logic [NP-1:0] meta_ff;
    logic [NP-1:0] pin_ff;
    logic [NP-1:0] scan_ff;
    logic [NP-1:0] prev_ff;
    logic          tick_d_ff;
    logic          scan_tick;
    logic [NP-1:0] rise;
    logic [NP-1:0] pins;

    assign pins = {I_HANDLE_MODE, I_ERROR_TEMP_CANCEL,
                   I_PHASE_OFFSET_REQUEST, I_PHASE_SHIFT_CALC_REQUEST,
                   I_ROT_DIR_REVERSE, I_PHASE_SYNC_REQUEST,
                   I_SPINDLE_SYNC_REQUEST};

    scan_divider #(.CYCLES(SCAN_CYCLES)) u_scan
    (
        .i_clock (I_CLOCK),
        .i_rst   (I_RST),
        .o_tick  (scan_tick)
    );

    // Two flops per pin, then one sample per scan tick.
    always_ff @(posedge I_CLOCK or posedge I_RST)
    begin
        if (I_RST)
        begin
            meta_ff   <= '0;
            pin_ff    <= '0;
            scan_ff   <= '0;
            prev_ff   <= '0;
            tick_d_ff <= 1'b0;
        end
        else
        begin
            meta_ff   <= pins;
            pin_ff    <= meta_ff;
            tick_d_ff <= scan_tick;
            if (scan_tick)
            begin
                prev_ff <= scan_ff;
                scan_ff <= pin_ff;
            end
        end
    end

    // Edges exist for one cycle after each scan.
    assign rise = tick_d_ff ? (scan_ff & ~prev_ff) : '0;

    // ------------------------------------------------------------------
    // Control state
    // ------------------------------------------------------------------
    spsync_pkg::mode_e mode_ff, nxt_mode;
    logic [POS_W-1:0]  err_ff, nxt_err;
    logic              saved_ff, nxt_saved;
    logic              done_ff, nxt_done;
    logic [POS_W-1:0]  tgt_ff, nxt_tgt;
    logic [POS_W-1:0]  canc_ff, nxt_canc;
    logic [SPD_W-1:0]  spd_ff, nxt_spd;
    logic [POS_W-1:0]  pos_ff, nxt_pos;
    logic              spdok_ff, nxt_spdok;
    logic              phok_ff, nxt_phok;
    logic              align_ff, nxt_align;
    logic              hstep_ff, nxt_hstep;
    logic [CW-1:0]     cmd_ff;
    logic [31:0]       offs_ff;
    logic              in_sync;
    logic              rev;
    logic              calc;
    logic              store;
    logic [POS_W-1:0]  phase_now;
    logic [POS_W-1:0]  cancel_term;
    logic [SPD_W:0]    sdiff;
    logic [SPD_W:0]    smag;

    assign in_sync     = (mode_ff != spsync_pkg::MODE_IDLE);
    assign rev         = scan_ff[spsync_pkg::PIN_REV];
    assign calc        = scan_ff[spsync_pkg::PIN_CALC];
    assign phase_now   = pdiff(I_BASIC_POS, I_SYNC_POS, rev);
    // The capture is subtracted for as long as cancel is held.
    assign cancel_term = scan_ff[spsync_pkg::PIN_CANCEL] ? canc_ff : '0;
    // Save once per request, plain command, speed reached.
    assign store = in_sync && calc && !done_ff && spdok_ff
                   && cmd_ff[spsync_pkg::CMD_ROT_SYNC]
                   && !cmd_ff[spsync_pkg::CMD_PHASE_SYNC];
    assign sdiff = {spd_ff[SPD_W-1], spd_ff}
                   - {I_SYNC_SPEED[SPD_W-1], I_SYNC_SPEED};
    assign smag  = sdiff[SPD_W] ? (SPD_W+1)'(~sdiff + 1'b1) : sdiff;

    // Next values of the mode, stored errors and spindle commands.
    always_comb
    begin
        nxt_mode = mode_ff;
        case (mode_ff)
            spsync_pkg::MODE_IDLE:
                if (scan_ff[spsync_pkg::PIN_SYNC])
                    nxt_mode = spsync_pkg::MODE_SPEED;
            spsync_pkg::MODE_SPEED:
                if (!scan_ff[spsync_pkg::PIN_SYNC])
                    nxt_mode = spsync_pkg::MODE_IDLE;
                else if (rise[spsync_pkg::PIN_PHASE])
                    nxt_mode = spsync_pkg::MODE_PHASE;
            spsync_pkg::MODE_PHASE:
                if (!scan_ff[spsync_pkg::PIN_SYNC])
                    nxt_mode = spsync_pkg::MODE_IDLE;
                else if (!scan_ff[spsync_pkg::PIN_PHASE])
                    nxt_mode = spsync_pkg::MODE_SPEED;
            default:
                nxt_mode = spsync_pkg::MODE_IDLE;
        endcase
        nxt_err   = store ? phase_now : err_ff;
        nxt_saved = saved_ff || store;
        nxt_done  = calc && (done_ff || store);
        // Offset alone, or offset on top of the saved error.
        if (!cmd_ff[spsync_pkg::CMD_PHASE_SYNC])
            nxt_tgt = '0;
        else if (scan_ff[spsync_pkg::PIN_OFFS])
            nxt_tgt = POS_W'(err_ff + offs_ff[POS_W-1:0]);
        else
            nxt_tgt = offs_ff[POS_W-1:0];
        // Capture deviation from target on the cancel edge.
        nxt_canc = canc_ff;
        if (in_sync && rise[spsync_pkg::PIN_CANCEL])
            nxt_canc = POS_W'(phase_now - tgt_ff);
        // Same or reverse direction for the speed command.
        if (!in_sync)
            nxt_spd = '0;
        else if (rev)
            nxt_spd = SPD_W'(~I_BASIC_SPEED + 1'b1);
        else
            nxt_spd = I_BASIC_SPEED;
        // Alignment is held off while calculating.
        nxt_align = (mode_ff == spsync_pkg::MODE_PHASE) && !calc;
        // Position target; chuck state plays no part here.
        nxt_pos = rev ? POS_W'(tgt_ff + cancel_term - I_BASIC_POS)
                      : POS_W'(I_BASIC_POS - tgt_ff - cancel_term);
        nxt_spdok = in_sync && (smag <= (SPD_W+1)'(SPEED_TOL));
        nxt_phok  = align_ff
                    && near_zero(POS_W'(phase_now - tgt_ff - cancel_term));
        // Handle pulses are blocked in handle mode.
        nxt_hstep = I_HANDLE_PULSE && !in_sync
                    && !scan_ff[spsync_pkg::PIN_HANDLE];
    end

    // Register the control state; stored errors clear on reset.
    always_ff @(posedge I_CLOCK or posedge I_RST)
    begin
        if (I_RST)
        begin
            mode_ff  <= spsync_pkg::MODE_IDLE;
            err_ff   <= '0;
            saved_ff <= 1'b0;
            done_ff  <= 1'b0;
            tgt_ff   <= '0;
            canc_ff  <= '0;
            spd_ff   <= '0;
            pos_ff   <= '0;
            spdok_ff <= 1'b0;
            phok_ff  <= 1'b0;
            align_ff <= 1'b0;
            hstep_ff <= 1'b0;
        end
        else
        begin
            mode_ff  <= nxt_mode;
            err_ff   <= nxt_err;
            saved_ff <= nxt_saved;
            done_ff  <= nxt_done;
            tgt_ff   <= nxt_tgt;
            canc_ff  <= nxt_canc;
            spd_ff   <= nxt_spd;
            pos_ff   <= nxt_pos;
            spdok_ff <= nxt_spdok;
            phok_ff  <= nxt_phok;
            align_ff <= nxt_align;
            hstep_ff <= nxt_hstep;
        end
    end

    assign O_IN_SPINDLE_SYNC_FLAG = in_sync;
    assign O_SPEED_SYNC_COMPLETE  = spdok_ff;
    assign O_PHASE_SYNC_COMPLETE  = phok_ff;
    assign O_PHASE_ALIGN_EN       = align_ff;
    assign O_SYNC_SPEED_CMD       = spd_ff;
    assign O_SYNC_POS_TARGET      = pos_ff;
    assign O_SYNC_HANDLE_STEP     = hstep_ff;

    // ------------------------------------------------------------------
    // Wishbone slave
    // ------------------------------------------------------------------
    logic          ack_ff, nxt_ack;
    logic [31:0]   rdat_ff, nxt_rdat;
    logic [CW-1:0] nxt_cmd;
    logic [31:0]   nxt_offs;
    logic [31:0]   cmd_word;
    logic [31:0]   status;
    logic          take;
    logic          wr_now;

    assign take     = I_WB_CYC && I_WB_STB && !ack_ff;
    assign wr_now   = I_WB_CYC && I_WB_STB && I_WB_WE && ack_ff;
    assign cmd_word = {{(32-CW){1'b0}}, cmd_ff};
    assign status   = {{(32-spsync_pkg::ST_W){1'b0}}, align_ff, rev,
                       scan_ff[spsync_pkg::PIN_CANCEL], saved_ff,
                       calc && !done_ff, phok_ff, spdok_ff, in_sync};

    // Decode, write under byte enables, and pick read data.
    always_comb
    begin
        nxt_ack  = take;
        nxt_cmd  = cmd_ff;
        nxt_offs = offs_ff;
        nxt_rdat = rdat_ff;
        if (take)
        begin
            nxt_rdat = spsync_pkg::WORD_ZERO;
            case (I_WB_ADR)
                spsync_pkg::ADR_COMMAND:
                    nxt_rdat = cmd_word;
                spsync_pkg::ADR_OFFSET:
                    nxt_rdat = offs_ff;
                spsync_pkg::ADR_STATUS:
                    nxt_rdat = status;
                spsync_pkg::ADR_PHASE_ERR:
                    nxt_rdat = 32'(err_ff);
                spsync_pkg::ADR_CANCEL_DIFF:
                    nxt_rdat = 32'(canc_ff);
                default:
                    nxt_rdat = spsync_pkg::WORD_ZERO;
            endcase
        end
        // Writes land at the edge where the master sees ack high.
        if (wr_now && (I_WB_ADR == spsync_pkg::ADR_COMMAND))
            nxt_cmd = CW'(wmerge(cmd_word, I_WB_DAT, I_WB_SEL));
        if (wr_now && (I_WB_ADR == spsync_pkg::ADR_OFFSET))
            nxt_offs = wmerge(offs_ff, I_WB_DAT, I_WB_SEL);
    end

    // Register the bus state.
    always_ff @(posedge I_CLOCK or posedge I_RST)
    begin
        if (I_RST)
        begin
            ack_ff  <= 1'b0;
            rdat_ff <= spsync_pkg::WORD_ZERO;
            cmd_ff  <= '0;
            offs_ff <= spsync_pkg::WORD_ZERO;
        end
        else
        begin
            ack_ff  <= nxt_ack;
            rdat_ff <= nxt_rdat;
            cmd_ff  <= nxt_cmd;
            offs_ff <= nxt_offs;
        end
    end

    assign O_WB_ACK = ack_ff;
    assign O_WB_DAT = rdat_ff;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge I_CLOCK); endclocking
    default disable iff (I_RST);

    sequence s_cancel_rise;
        in_sync && rise[spsync_pkg::PIN_CANCEL];
    endsequence

    sequence s_cancel_held;
        (scan_ff[spsync_pkg::PIN_CANCEL] && in_sync) [*3];
    endsequence

    rot_dir_cmd_a: assert property (in_sync && !rev |=>
        O_SYNC_SPEED_CMD == $past(I_BASIC_SPEED))
        else $error("Same-direction speed command wrong.");
    calc_store_a: assert property (store |=>
        err_ff == $past(phase_now) && saved_ff ##1 !store)
        else $error("Phase error not saved once.");
    no_align_calc_a: assert property (calc |=>
        !O_PHASE_ALIGN_EN)
        else $error("Alignment during calculation.");
    handle_block_a: assert property (
        scan_ff[spsync_pkg::PIN_HANDLE] |=> !O_SYNC_HANDLE_STEP)
        else $error("Handle pulse passed in handle mode.");
    offset_sum_a: assert property (
        cmd_ff[spsync_pkg::CMD_PHASE_SYNC] && scan_ff[spsync_pkg::PIN_OFFS]
        |=> tgt_ff == POS_W'($past(err_ff) + $past(offs_ff[POS_W-1:0])))
        else $error("Offset target is not saved plus offset.");
    cancel_capture_a: assert property (s_cancel_rise |=>
        canc_ff == POS_W'($past(phase_now) - $past(tgt_ff)))
        else $error("Cancel capture wrong.");
    cancel_hold_a: assert property (s_cancel_rise ##1
        s_cancel_held |-> cancel_term == canc_ff && $stable(canc_ff))
        else $error("Cancel term not held.");
    sync_enter_a: assert property (!in_sync &&
        scan_ff[spsync_pkg::PIN_SYNC] |=> in_sync ##1 spd_ff ==
        ($past(rev) ? SPD_W'(~$past(I_BASIC_SPEED) + 1'b1)
                    : $past(I_BASIC_SPEED)))
        else $error("Sync mode not entered.");
    phase_ignore_a: assert property (
        mode_ff != spsync_pkg::MODE_PHASE
        && !(in_sync && rise[spsync_pkg::PIN_PHASE])
        |=> mode_ff != spsync_pkg::MODE_PHASE)
        else $error("Phase mode entered without a new request.");
    scan_edge_a: assert property (|rise |->
        $past(scan_tick) && $past(scan_ff) == prev_ff)
        else $error("Edge outside scan sample.");
endmodule // spindle_sync_phase_control

// ==== verilog/spsync_pkg.sv ====
// Shared constants and types for the spindle synchronous control block.
package spsync_pkg;
    // ------------------------------------------------------------------
    // Clock and scan timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_NS       = 8;
    localparam int unsigned SCAN_TIME_NS = 1000;
    localparam int unsigned SCAN_CYCLES  = (SCAN_TIME_NS + CLK_NS - 1)
                                           / CLK_NS;
    // ------------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------------
    localparam int unsigned     ADR_W           = 8;
    localparam logic [ADR_W-1:0] ADR_COMMAND     = 8'h00;
    localparam logic [ADR_W-1:0] ADR_OFFSET      = 8'h04;
    localparam logic [ADR_W-1:0] ADR_STATUS      = 8'h08;
    localparam logic [ADR_W-1:0] ADR_PHASE_ERR   = 8'h0C;
    localparam logic [ADR_W-1:0] ADR_CANCEL_DIFF = 8'h10;
    localparam logic [31:0]      WORD_ZERO       = 32'h0000_0000;
    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int unsigned CMD_ROT_SYNC   = 0;
    localparam int unsigned CMD_PHASE_SYNC = 1;
    localparam int unsigned CMD_W          = 2;
    localparam int unsigned ST_IN_SYNC     = 0;
    localparam int unsigned ST_SPEED_OK    = 1;
    localparam int unsigned ST_PHASE_OK    = 2;
    localparam int unsigned ST_CALC_BUSY   = 3;
    localparam int unsigned ST_ERR_SAVED   = 4;
    localparam int unsigned ST_CANCEL      = 5;
    localparam int unsigned ST_REVERSE     = 6;
    localparam int unsigned ST_ALIGN       = 7;
    localparam int unsigned ST_W           = 8;
    // Request pin positions inside the sampled vector.
    localparam int unsigned PIN_SYNC   = 0;
    localparam int unsigned PIN_PHASE  = 1;
    localparam int unsigned PIN_REV    = 2;
    localparam int unsigned PIN_CALC   = 3;
    localparam int unsigned PIN_OFFS   = 4;
    localparam int unsigned PIN_CANCEL = 5;
    localparam int unsigned PIN_HANDLE = 6;
    localparam int unsigned PIN_COUNT  = 7;
    // ------------------------------------------------------------------
    // Control modes
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {MODE_IDLE, MODE_SPEED, MODE_PHASE} mode_e;
endpackage
